// ---- hw/dcr_clock_pick.sv ----
// dcr_clock_pick: decodes the clock select fields and holds the last legal selection
// assumes the fields come straight from the register flops
`timescale 1ns/1ps
module dcr_clock_pick
   import dcr_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic programmable_clock_pick,
   input wire logic clock_pick_high,
   input wire logic [1:0] clock_pick_low,
   input wire logic [1:0] video_clock_divider,
   output logic [2:0] clk_sel_q,
   output logic [1:0] clk_div_q,
   output logic sel_reserved_q
);
   logic legal_sel;
   logic [2:0] sel_d;
   // ****************
   // selection decode
   // ****************
   always_comb
   begin
      legal_sel = 1'b1;
      sel_d = clk_sel_q;
      unique case ({programmable_clock_pick, clock_pick_high, clock_pick_low})
         4'h0: sel_d = DCR_CLK_TEXT8;
         4'h1: sel_d = DCR_CLK_TEXT9;
         4'h2: sel_d = DCR_CLK_EXT;
         4'h3: sel_d = DCR_CLK_HIRES;
         4'h4: sel_d = DCR_CLK_COL132;
         4'h8: sel_d = DCR_CLK_PROG;
         default: legal_sel = 1'b0;
      endcase
   end
   // ****************
   // held selection
   // ****************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         clk_sel_q <= DCR_SEL_RESET;
      end
      else if (legal_sel)
      begin
         clk_sel_q <= sel_d;
      end
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         clk_div_q <= DCR_DIV_RESET;
      end
      else if (video_clock_divider == DCR_DIV_BY1 || video_clock_divider == DCR_DIV_BY2)
      begin
         clk_div_q <= video_clock_divider;
      end
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sel_reserved_q <= 1'b0;
      end
      else
      begin
         sel_reserved_q <= ~legal_sel | (video_clock_divider[1]);
      end
   end
endmodule : dcr_clock_pick

// ---- hw/dcr_pixel_clock.sv ----
// dcr_pixel_clock: divides the chosen video clock enable and forms the programmed frequency
// assumes the source pulses arrive as one-cycle clock enables
`timescale 1ns/1ps
module dcr_pixel_clock
   import dcr_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic src_tick,
   input wire logic [1:0] clk_div,
   input wire logic [5:0] freq_index,
   output logic pixel_tick_q,
   output logic [7:0] freq_times_div_q
);
   logic phase_q;
   // ****************
   // scaling
   // ****************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         phase_q <= 1'b0;
      end
      else if (src_tick)
      begin
         phase_q <= (clk_div == DCR_DIV_BY2) ? ~phase_q : 1'b0;
      end
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pixel_tick_q <= 1'b0;
      end
      else
      begin
         pixel_tick_q <= src_tick & ((clk_div == DCR_DIV_BY1) | phase_q);
      end
   end
   // ****************
   // programmed frequency
   // ****************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         freq_times_div_q <= DCR_FREQ_OFFSET;
      end
      else
      begin
         freq_times_div_q <= {2'h0, freq_index} + DCR_FREQ_OFFSET;
      end
   end
endmodule : dcr_pixel_clock

// ---- hw/dcr_pkg.sv ----
// dcr_pkg: register indexes, field positions and clock codes for the display control registers
// assumes an 8-bit indexed register port and a single 40 MHz clock
package dcr_pkg;
   // ****************
   // register indexes
   // ****************
   localparam logic [7:0] DCR_IDX_CLK_ONE = 8'h54;
   localparam logic [7:0] DCR_IDX_SPR_DATA = 8'h6A;
   localparam logic [7:0] DCR_IDX_SPR_PREF = 8'h6B;
   localparam logic [7:0] DCR_IDX_MISC = 8'h6C;
   localparam logic [7:0] DCR_IDX_CURSOR = 8'h6D;
   localparam logic [7:0] DCR_IDX_CLK_TWO = 8'h70;
   localparam logic [7:0] DCR_IDX_SPR_LOW = 8'h60;
   localparam logic [7:0] DCR_IDX_SPR_HIGH = 8'h61;
   localparam logic [7:0] DCR_IDX_PREF_LOW = 8'h62;
   localparam logic [7:0] DCR_IDX_PREF_HIGH = 8'h63;
   // ****************
   // field positions
   // ****************
   localparam int DCR_BIT_BLANK = 0;
   localparam int DCR_BIT_ATTR_EN = 0;
   localparam int DCR_BIT_STYLE = 1;
   localparam int DCR_BIT_BLINK_OFF = 2;
   localparam int DCR_BIT_CONST_COL = 3;
   localparam int DCR_COL_HI = 7;
   localparam int DCR_COL_LO = 4;
   localparam int DCR_BIT_PROG = 7;
   localparam int DCR_BIT_PICK_HIGH = 7;
   localparam int DCR_PICK_LOW_HI = 3;
   localparam int DCR_PICK_LOW_LO = 2;
   localparam int DCR_DIV_HI = 1;
   localparam int DCR_DIV_LO = 0;
   // ****************
   // reset values and widths
   // ****************
   localparam logic [7:0] DCR_REG_RESET = 8'h00;
   localparam logic [7:0] DCR_MISC_USED = 8'h01;
   localparam int DCR_SPRITE_WORDS = 16384;
   localparam int DCR_SPRITE_AW = 14;
   localparam logic [13:0] DCR_IDX_ONE = 14'h0001;
   localparam logic [7:0] DCR_FREQ_OFFSET = 8'h41;
   localparam logic [2:0] DCR_SEL_RESET = 3'h0;
   localparam logic [1:0] DCR_DIV_RESET = 2'h0;
   // ****************
   // clock choices
   // ****************
   typedef enum logic [2:0]
   {
      DCR_CLK_TEXT8 = 3'h0,
      DCR_CLK_TEXT9 = 3'h1,
      DCR_CLK_EXT = 3'h2,
      DCR_CLK_HIRES = 3'h3,
      DCR_CLK_COL132 = 3'h4,
      DCR_CLK_PROG = 3'h5
   } dcr_clk_type;
   localparam logic [1:0] DCR_DIV_BY1 = 2'h0;
   localparam logic [1:0] DCR_DIV_BY2 = 2'h1;
endpackage : dcr_pkg

// ---- hw/dcr_regs.sv ----
// dcr_regs: indexed display control registers, sprite window, cursor and clock control
// assumes a one-cycle strobe port synchronous to clk and one pixel clock domain
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module dcr_regs
   import dcr_pkg::*;
#(
   parameter int SPRITE_WORDS = DCR_SPRITE_WORDS
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic host_terminal_mode,
   input wire logic [7:0] dac_red_in,
   input wire logic [7:0] dac_blue_in,
   output logic [7:0] dac_red_out,
   output logic [7:0] dac_blue_out,
   input wire logic [3:0] char_fg_colour,
   input wire logic [3:0] char_bg_colour,
   input wire logic cursor_here,
   input wire logic blink_phase,
   output logic cursor_show,
   output logic [3:0] cursor_fg_colour,
   output logic [3:0] cursor_bg_colour,
   output logic terminal_attr_active,
   input wire logic [5:0] freq_index,
   input wire logic [5:0] src_ticks,
   output logic [2:0] clk_sel,
   output logic pixel_tick,
   output logic [7:0] freq_times_div,
   output logic clk_reserved
);
   logic [7:0] sprite_mem [SPRITE_WORDS];
   logic [13:0] spr_idx_q;
   logic [13:0] pref_idx_q;
   logic [7:0] spr_pref_q;
   logic [7:0] misc_q;
   logic [7:0] cursor_q;
   logic [7:0] clk_one_q;
   logic [7:0] clk_two_q;
   logic [7:0] rdata_d;
   logic cursor_ok;
   logic [2:0] sel_w;
   logic [1:0] div_w;
   logic res_w;
   logic tick_w;
   logic [7:0] ftd_w;
   logic src_sel;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
      hit = (a == idx);
   endfunction : hit

   assign cursor_ok = host_terminal_mode;
   // ****************
   // sprite index and buffer
   // ****************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         spr_idx_q <= '0;
      end
      else if (reg_wr && hit(reg_addr, DCR_IDX_SPR_LOW))
      begin
         spr_idx_q <= {spr_idx_q[13:8], reg_wdata};
      end
      else if (reg_wr && hit(reg_addr, DCR_IDX_SPR_HIGH))
      begin
         spr_idx_q <= {reg_wdata[5:0], spr_idx_q[7:0]};
      end
      else if (reg_wr && hit(reg_addr, DCR_IDX_SPR_DATA))
      begin
         spr_idx_q <= spr_idx_q + DCR_IDX_ONE;
      end
   end
   always_ff @(posedge clk)
   begin
      if (reg_wr && hit(reg_addr, DCR_IDX_SPR_DATA))
      begin
         sprite_mem[spr_idx_q] <= reg_wdata;
      end
   end
   // ****************
   // prefetch index and latch
   // ****************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pref_idx_q <= '0;
      end
      else if (reg_wr && hit(reg_addr, DCR_IDX_PREF_LOW))
      begin
         pref_idx_q <= {pref_idx_q[13:8], reg_wdata} + DCR_IDX_ONE;
      end
      else if (reg_wr && hit(reg_addr, DCR_IDX_PREF_HIGH))
      begin
         pref_idx_q <= {reg_wdata[5:0], pref_idx_q[7:0]} + DCR_IDX_ONE;
      end
      else if (reg_rd && hit(reg_addr, DCR_IDX_SPR_DATA))
      begin
         pref_idx_q <= pref_idx_q + DCR_IDX_ONE;
      end
   end
   always_ff @(posedge clk)
   begin
      if (reg_wr && hit(reg_addr, DCR_IDX_SPR_PREF))
      begin
         spr_pref_q <= reg_wdata;
      end
      else if (reg_wr && hit(reg_addr, DCR_IDX_PREF_LOW))
      begin
         spr_pref_q <= sprite_mem[{pref_idx_q[13:8], reg_wdata}];
      end
      else if (reg_wr && hit(reg_addr, DCR_IDX_PREF_HIGH))
      begin
         spr_pref_q <= sprite_mem[{reg_wdata[5:0], pref_idx_q[7:0]}];
      end
      else if (reg_rd && hit(reg_addr, DCR_IDX_SPR_DATA))
      begin
         spr_pref_q <= sprite_mem[pref_idx_q];
      end
   end
   // ****************
   // control registers
   // ****************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         misc_q <= DCR_REG_RESET;
      end
      else if (reg_wr && hit(reg_addr, DCR_IDX_MISC))
      begin
         misc_q <= reg_wdata & DCR_MISC_USED;
      end
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cursor_q <= DCR_REG_RESET;
      end
      else if (reg_wr && hit(reg_addr, DCR_IDX_CURSOR) && cursor_ok)
      begin
         cursor_q <= reg_wdata;
      end
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         clk_one_q <= DCR_REG_RESET;
      end
      else if (reg_wr && hit(reg_addr, DCR_IDX_CLK_ONE))
      begin
         clk_one_q <= reg_wdata;
      end
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         clk_two_q <= DCR_REG_RESET;
      end
      else if (reg_wr && hit(reg_addr, DCR_IDX_CLK_TWO))
      begin
         clk_two_q <= reg_wdata;
      end
   end
   // ****************
   // read port
   // ****************
   always_comb
   begin
      rdata_d = DCR_REG_RESET;
      if (hit(reg_addr, DCR_IDX_SPR_DATA))
         rdata_d = spr_pref_q;
      else if (hit(reg_addr, DCR_IDX_SPR_PREF))
         rdata_d = spr_pref_q;
      else if (hit(reg_addr, DCR_IDX_MISC))
         rdata_d = misc_q;
      else if (hit(reg_addr, DCR_IDX_CURSOR) && cursor_ok)
         rdata_d = cursor_q;
      else if (hit(reg_addr, DCR_IDX_CLK_ONE))
         rdata_d = clk_one_q;
      else if (hit(reg_addr, DCR_IDX_CLK_TWO))
         rdata_d = clk_two_q;
      else if (hit(reg_addr, DCR_IDX_SPR_LOW))
         rdata_d = spr_idx_q[7:0];
      else if (hit(reg_addr, DCR_IDX_SPR_HIGH))
         rdata_d = {2'h0, spr_idx_q[13:8]};
      else if (hit(reg_addr, DCR_IDX_PREF_LOW))
         rdata_d = pref_idx_q[7:0];
      else if (hit(reg_addr, DCR_IDX_PREF_HIGH))
         rdata_d = {2'h0, pref_idx_q[13:8]};
   end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         reg_rdata <= DCR_REG_RESET;
      end
      else
      begin
         reg_rdata <= reg_rd ? rdata_d : DCR_REG_RESET;
      end
   end
   // ****************
   // colour converters
   // ****************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         dac_red_out <= DCR_REG_RESET;
         dac_blue_out <= DCR_REG_RESET;
      end
      else
      begin
         dac_red_out <= misc_q[DCR_BIT_BLANK] ? DCR_REG_RESET : dac_red_in;
         dac_blue_out <= misc_q[DCR_BIT_BLANK] ? DCR_REG_RESET : dac_blue_in;
      end
   end
   // ****************
   // terminal cursor
   // ****************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cursor_show <= 1'b0;
         cursor_fg_colour <= '0;
         cursor_bg_colour <= '0;
         terminal_attr_active <= 1'b0;
      end
      else
      begin
         terminal_attr_active <= host_terminal_mode & cursor_q[DCR_BIT_ATTR_EN];
         cursor_show <= host_terminal_mode & cursor_q[DCR_BIT_ATTR_EN] & cursor_here
            & (cursor_q[DCR_BIT_BLINK_OFF] | blink_phase);
         if (cursor_q[DCR_BIT_STYLE])
         begin
            cursor_fg_colour <= char_bg_colour;
            cursor_bg_colour <= char_fg_colour;
         end
         else if (cursor_q[DCR_BIT_CONST_COL])
         begin
            cursor_fg_colour <= cursor_q[DCR_COL_HI:DCR_COL_LO];
            cursor_bg_colour <= cursor_q[DCR_COL_HI:DCR_COL_LO];
         end
         else
         begin
            cursor_fg_colour <= char_fg_colour;
            cursor_bg_colour <= char_fg_colour;
         end
      end
   end
   // ****************
   // clock selection
   // ****************
   dcr_clock_pick u_pick
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .programmable_clock_pick(clk_one_q[DCR_BIT_PROG]),
      .clock_pick_high(clk_two_q[DCR_BIT_PICK_HIGH]),
      .clock_pick_low(clk_one_q[DCR_PICK_LOW_HI:DCR_PICK_LOW_LO]),
      .video_clock_divider(clk_one_q[DCR_DIV_HI:DCR_DIV_LO]),
      .clk_sel_q(sel_w),
      .clk_div_q(div_w),
      .sel_reserved_q(res_w)
   );
   assign src_sel = src_ticks[sel_w];
   dcr_pixel_clock u_pix
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .src_tick(src_sel),
      .clk_div(div_w),
      .freq_index(freq_index),
      .pixel_tick_q(tick_w),
      .freq_times_div_q(ftd_w)
   );
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         clk_sel <= DCR_SEL_RESET;
         pixel_tick <= 1'b0;
         freq_times_div <= DCR_FREQ_OFFSET;
         clk_reserved <= 1'b0;
      end
      else
      begin
         clk_sel <= sel_w;
         pixel_tick <= tick_w;
         freq_times_div <= ftd_w;
         clk_reserved <= res_w;
      end
   end
endmodule : dcr_regs

// ---- verification/dcr_regs_chk.sv ----
// dcr_regs_chk: port-level assertions for the display control registers
// assumes a single clock domain and the dcr_regs port names
`timescale 1ns/1ps
module dcr_regs_chk
   import dcr_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic host_terminal_mode,
   input wire logic cursor_here,
   input wire logic [7:0] dac_red_out,
   input wire logic [7:0] dac_blue_out,
   input wire logic cursor_show,
   input wire logic [5:0] freq_index,
   input wire logic [2:0] clk_sel,
   input wire logic [7:0] freq_times_div,
   input wire logic clk_reserved
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   logic clk_wr;
   assign clk_wr = reg_wr && (reg_addr == DCR_IDX_CLK_ONE || reg_addr == DCR_IDX_CLK_TWO);
   // ****************
   // assertions
   // ****************
   a_blank_forces_zero: assert property (
      reg_wr && reg_addr == DCR_IDX_MISC && reg_wdata[0] |-> ##3 (dac_red_out == 8'h00 && dac_blue_out == 8'h00))
      else $error("red or blue output not blanked");
   a_cursor_read_refused: assert property (
      reg_rd && reg_addr == DCR_IDX_CURSOR && !host_terminal_mode |=> reg_rdata == 8'h00)
      else $error("cursor register read outside terminal mode");
   a_misc_read_clean: assert property (
      reg_rd && reg_addr == DCR_IDX_MISC |=> reg_rdata[7:1] == 7'h00)
      else $error("unused control bits read nonzero");
   a_freq_index_sum: assert property (
      $stable(freq_index) && $past(freq_index) == $past(freq_index, 2)
      |-> freq_times_div == {2'h0, freq_index} + DCR_FREQ_OFFSET)
      else $error("frequency sum wrong");
   a_sel_code_legal: assert property (
      clk_sel <= 3'h5)
      else $error("clock selection out of range");
   a_sel_change_cause: assert property (
      $changed(clk_sel) |-> $past(clk_wr) || $past(clk_wr, 2) || $past(clk_wr, 3) || $past(clk_wr, 4))
      else $error("clock selection changed without a write");
   a_scale_reserved_flag: assert property (
      reg_wr && reg_addr == DCR_IDX_CLK_ONE && reg_wdata[1] |-> ##[1:3] clk_reserved)
      else $error("reserved scale not flagged");
   a_cursor_needs_place: assert property (
      !$past(cursor_here) && !$past(cursor_here, 2) |-> !cursor_show)
      else $error("cursor shown away from its place");
   c_blank_write: cover property (reg_wr && reg_addr == DCR_IDX_MISC && reg_wdata[0]);
   c_reserved_seen: cover property (clk_reserved);
   c_cursor_seen: cover property (cursor_show);
endmodule : dcr_regs_chk
bind dcr_regs dcr_regs_chk u_dcr_regs_chk
(
   .clk(clk),
   .sys_rst(sys_rst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .host_terminal_mode(host_terminal_mode),
   .cursor_here(cursor_here),
   .dac_red_out(dac_red_out),
   .dac_blue_out(dac_blue_out),
   .cursor_show(cursor_show),
   .freq_index(freq_index),
   .clk_sel(clk_sel),
   .freq_times_div(freq_times_div),
   .clk_reserved(clk_reserved)
);

// ---- verification/dcr_regs_test.sv ----
// dcr_regs_test: self-checking bench for the display control registers
// assumes dcr_pkg, dcr_regs and the bound checker
`timescale 1ns/1ps
module dcr_regs_test
   import dcr_pkg::*;
;
   logic clk, sys_rst, reg_wr, reg_rd, host_terminal_mode, cursor_here, blink_phase;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, dac_red_in, dac_blue_in, dac_red_out, dac_blue_out;
   logic [3:0] char_fg_colour, char_bg_colour, cursor_fg_colour, cursor_bg_colour;
   logic cursor_show, terminal_attr_active, pixel_tick, clk_reserved;
   logic [5:0] freq_index, src_ticks;
   logic [2:0] clk_sel, sel_exp;
   logic [7:0] freq_times_div;
   logic [7:0] got, c, c1, c2;
   logic [7:0] mem [4];
   logic [3:0] p, ef;
   int bad_count, comparisons, ticks;
   dcr_regs u_dcr_regs
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .host_terminal_mode(host_terminal_mode),
      .dac_red_in(dac_red_in),
      .dac_blue_in(dac_blue_in),
      .dac_red_out(dac_red_out),
      .dac_blue_out(dac_blue_out),
      .char_fg_colour(char_fg_colour),
      .char_bg_colour(char_bg_colour),
      .cursor_here(cursor_here),
      .blink_phase(blink_phase),
      .cursor_show(cursor_show),
      .cursor_fg_colour(cursor_fg_colour),
      .cursor_bg_colour(cursor_bg_colour),
      .terminal_attr_active(terminal_attr_active),
      .freq_index(freq_index),
      .src_ticks(src_ticks),
      .clk_sel(clk_sel),
      .pixel_tick(pixel_tick),
      .freq_times_div(freq_times_div),
      .clk_reserved(clk_reserved)
   );
   always #12.5 clk = ~clk;
   always @(posedge clk) if (pixel_tick === 1'b1) ticks <= ticks + 1;
   // ****************
   // tasks
   // ****************
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      got = reg_rdata;
   endtask : rd
   task automatic rw(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      wr(a, d);
      rd(a);
      chk("readback", e, got);
   endtask : rw
   function automatic logic [3:0] pick(input logic [7:0] one, input logic [7:0] two);
      case ({one[7], two[7], one[3:2]})
         4'h0: return 4'h8;
         4'h1: return 4'h9;
         4'h2: return 4'hA;
         4'h3: return 4'hB;
         4'h4: return 4'hC;
         4'h8: return 4'hD;
         default: return 4'h0;
      endcase
   endfunction : pick
   task automatic clk_wr(input logic [7:0] a, input logic [7:0] d);
      wr(a, d);
      p = (a == DCR_IDX_CLK_ONE) ? pick(d, c2) : pick(c1, d);
      if (a == DCR_IDX_CLK_ONE) c1 = d;
      else c2 = d;
      if (p[3]) sel_exp = p[2:0];
      repeat (4) @(posedge clk);
   endtask : clk_wr
   task automatic pulses(input int bitn, input logic [7:0] exp);
      @(negedge clk);
      ticks = 0;
      repeat (10)
      begin
         @(posedge clk);
         src_ticks <= 6'h01 << bitn;
         @(posedge clk);
         src_ticks <= 6'h00;
         @(posedge clk);
      end
      repeat (6) @(posedge clk);
      chk("pixel_ticks", exp, ticks[7:0]);
   endtask : pulses
   task automatic complete_run();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run
   // ****************
   // sequence
   // ****************
   initial
   begin
      #400000;
      bad_count++;
      complete_run();
   end
   initial
   begin
      {clk, reg_wr, reg_rd, host_terminal_mode, cursor_here, blink_phase} = 6'h00;
      {reg_addr, reg_wdata, dac_red_in, dac_blue_in, char_fg_colour, char_bg_colour} = 40'h0;
      {freq_index, src_ticks, c1, c2, sel_exp} = 31'h0;
      sys_rst = 1'b1;
      void'($urandom(19623));
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      chk("freq_reset", 8'h41, freq_times_div);
      rd(8'h00);
      chk("unmapped", 8'h00, got);
      rd(DCR_IDX_CURSOR);
      chk("cursor_locked", 8'h00, got);
      c = 8'($urandom);
      rw(DCR_IDX_SPR_PREF, c, c);
      @(posedge clk) host_terminal_mode <= 1'b1;
      rw(DCR_IDX_CURSOR, 8'hA5, 8'hA5);
      @(posedge clk) host_terminal_mode <= 1'b0;
      rw(DCR_IDX_CURSOR, 8'h5A, 8'h00);
      @(posedge clk) host_terminal_mode <= 1'b1;
      rd(DCR_IDX_CURSOR);
      chk("cursor_kept", 8'hA5, got);
      @(posedge clk) dac_red_in <= 8'($urandom) | 8'h01;
      dac_blue_in <= 8'($urandom) | 8'h80;
      rw(DCR_IDX_MISC, 8'h01, 8'h01);
      chk("red_blank", 8'h00, dac_red_out);
      chk("blue_blank", 8'h00, dac_blue_out);
      rw(DCR_IDX_MISC, 8'h00, 8'h00);
      chk("red_pass", dac_red_in, dac_red_out);
      chk("blue_pass", dac_blue_in, dac_blue_out);
      for (int i = 0; i < 16; i++)
      begin
         clk_wr(DCR_IDX_CLK_TWO, {i[2], 7'($urandom)});
         clk_wr(DCR_IDX_CLK_ONE, {i[3], 3'($urandom), i[1:0], 1'b0, (i[3:0] == 4'h3 || i[3:0] == 4'h4)});
         chk("clk_sel", {5'h00, sel_exp}, {5'h00, clk_sel});
         chk("clk_reserved", {7'h00, !p[3]}, {7'h00, clk_reserved});
         rd(DCR_IDX_CLK_ONE);
         chk("clk_one", c1, got);
      end
      clk_wr(DCR_IDX_CLK_TWO, 8'h00);
      clk_wr(DCR_IDX_CLK_ONE, 8'h00);
      pulses(0, 8'h0A);
      pulses(1, 8'h00);
      clk_wr(DCR_IDX_CLK_ONE, 8'h0D);
      pulses(3, 8'h05);
      clk_wr(DCR_IDX_CLK_ONE, 8'h0E);
      pulses(3, 8'h05);
      chk("scale_reserved", 8'h01, {7'h00, clk_reserved});
      clk_wr(DCR_IDX_CLK_ONE, 8'h80);
      pulses(5, 8'h0A);
      for (int k = 0; k < 8; k++)
      begin
         freq_index <= (k == 0) ? 6'h3F : 6'($urandom);
         repeat (3) @(posedge clk);
         chk("freq", {2'h0, freq_index} + 8'h41, freq_times_div);
      end
      cursor_here <= 1'b1;
      for (int k = 0; k < 32; k++)
      begin
         c = {4'($urandom), 4'(k)};
         blink_phase <= k[4];
         char_fg_colour <= 4'($urandom);
         char_bg_colour <= 4'($urandom);
         wr(DCR_IDX_CURSOR, c);
         repeat (3) @(posedge clk);
         chk("cursor_show", {7'h00, c[0] & (c[2] | k[4])}, {7'h00, cursor_show});
         chk("attr_active", {7'h00, c[0]}, {7'h00, terminal_attr_active});
         if (c[0])
         begin
            ef = c[1] ? char_bg_colour : (c[3] ? c[7:4] : char_fg_colour);
            chk("cursor_fg", {4'h0, ef}, {4'h0, cursor_fg_colour});
            ef = (c[1] | !c[3]) ? char_fg_colour : c[7:4];
            chk("cursor_bg", {4'h0, ef}, {4'h0, cursor_bg_colour});
         end
      end
      wr(DCR_IDX_SPR_LOW, 8'hFC);
      wr(DCR_IDX_SPR_HIGH, 8'h3F);
      for (int k = 0; k < 4; k++)
      begin
         mem[k] = 8'($urandom);
         wr(DCR_IDX_SPR_DATA, mem[k]);
      end
      // high byte first: each index write prefetches and steps the index
      wr(DCR_IDX_PREF_HIGH, 8'h3F);
      wr(DCR_IDX_PREF_LOW, 8'hFC);
      for (int k = 0; k < 4; k++)
      begin
         rd(DCR_IDX_SPR_DATA);
         chk("sprite", mem[k], got);
      end
      complete_run();
   end
endmodule : dcr_regs_test
